// ==== rtl/sgs_pkg.sv ====
/*
 sgs_pkg: register map, field layout, reset values, switching mode codes,
 control mode codes and timing constants of the servo gain switch selector.
 assumes a 32-bit apb slave on a 100 mhz pclk.
*/
// Function
// - switching only when second_gain_enable is one
// - mode 0 keeps first gain always
// - mode 1 keeps second gain always
// - mode 3: torque above level plus hysteresis
// - mode 3: torque low for delay returns
// - mode 4: velocity change above threshold switches
// - mode 4: velocity change low for delay
// - mode 4 holds first gain outside velocity
// - mode 5: velocity command magnitude with hysteresis
// - mode 6: position deviation magnitude with hysteresis
// - deviation units: encoder or external scale
// - deviation is command minus actual position
// - mode 7: nonzero position command switches
// - mode 8: not positioned switches, positioned returns
// - mode 9: actual speed magnitude with hysteresis
// - mode 10: command zero and slow returns
// - delay in 0.1 ms steps on return
// - hysteresis clamped to level when larger
// - position gain ramps, others switch at once
package sgs_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DLY_STEP_NS = 100_000;
    localparam int DLY_STEP_CYCLES = (DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] MODE_OFF = 8'h04;
    localparam logic [7:0] SET_BASE_OFF = 8'h08;
    localparam logic [7:0] SET_STRIDE = 8'h08;
    localparam logic [7:0] SET_DLY_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h20;
    localparam logic [7:0] RAMP_OFF = 8'h24;
    localparam int SETS = 3;

    // field layout
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CM_LSB = 1;
    localparam int MODE_W = 4;
    localparam int MODE_POS_LSB = 0;
    localparam int MODE_VEL_LSB = 4;
    localparam int MODE_TRQ_LSB = 8;
    localparam int LVL_W = 15;
    localparam int LVL_LSB = 0;
    localparam int HYS_LSB = 16;
    localparam int DLY_W = 14;
    localparam int STAT_GAIN_BIT = 0;
    localparam int STAT_TIMING_BIT = 1;
    localparam int STAT_WGT_LSB = 8;
    localparam int WGT_W = 8;
    localparam logic [WGT_W-1:0] WGT_MAX = 8'hFF;

    // reset values
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic [1:0] CTRL_CM_RST = 2'h0;
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
    localparam logic [LVL_W-1:0] LVL_RST = 15'h0000;
    localparam logic [LVL_W-1:0] HYS_RST = 15'h0000;
    localparam logic [DLY_W-1:0] DLY_RST = 14'h0000;
    localparam logic [DLY_W-1:0] RAMP_RST = 14'h0000;

    // control modes
    localparam logic [1:0] CM_POS = 2'h0;
    localparam logic [1:0] CM_VEL = 2'h1;
    localparam logic [1:0] CM_TRQ = 2'h2;
    localparam logic [1:0] CM_FULL = 2'h3;

    // switching modes
    localparam logic [MODE_W-1:0] SW_FIX_FIRST = 4'h0;
    localparam logic [MODE_W-1:0] SW_FIX_SECOND = 4'h1;
    localparam logic [MODE_W-1:0] SW_TORQUE = 4'h3;
    localparam logic [MODE_W-1:0] SW_VEL_CHG = 4'h4;
    localparam logic [MODE_W-1:0] SW_VEL_CMD = 4'h5;
    localparam logic [MODE_W-1:0] SW_POS_DEV = 4'h6;
    localparam logic [MODE_W-1:0] SW_POS_CMD = 4'h7;
    localparam logic [MODE_W-1:0] SW_NOT_INP = 4'h8;
    localparam logic [MODE_W-1:0] SW_ACT_SPD = 4'h9;
    localparam logic [MODE_W-1:0] SW_CMD_SPD = 4'hA;

    typedef enum logic {GAIN_FIRST, GAIN_SECOND} sgs_gain_e;

endpackage

// ==== rtl/sgs_delay_timer.sv ====
/*
 sgs_delay_timer: counts how long a return condition has held, in 0.1 ms steps.
 assumes run comes from logic on pclk; delay is a stable register value.
*/
`timescale 1ns/1ps
`default_nettype none
module sgs_delay_timer
    import sgs_pkg::*;
#(
    parameter int TICK_CYCLES = DLY_STEP_CYCLES,
    parameter int CW = $clog2(TICK_CYCLES + 1)
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [DLY_W-1:0] delay,
    output logic done,
    output logic busy
);

    localparam logic [CW-1:0] CYC_LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] cyc;
    logic [DLY_W-1:0] ticks;
    logic at_delay;

    assign at_delay = ticks >= delay;
    assign done = run && at_delay;
    assign busy = run && !at_delay;

    // prescaler restarts with the count, so the hold time is exact, not one step short
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc <= '0;
            ticks <= '0;
        end
        else if (!run)
        begin
            cyc <= '0;
            ticks <= '0;
        end
        else if (!at_delay)
        begin
            if (cyc == CYC_LAST)
            begin
                cyc <= '0;
                ticks <= ticks + 1'b1;
            end
            else
            begin
                cyc <= cyc + 1'b1;
            end
        end
    end

endmodule // sgs_delay_timer
`default_nettype wire

// ==== rtl/sgs_selector.sv ====
/*
 sgs_selector: chooses first or second servo gain set from the switching
 mode of the active control mode, with level, hysteresis and return delay,
 and ramps the position loop gain weight toward the chosen set.
 assumes all process inputs are signed values from logic on pclk, and an
 apb master that keeps psel/penable protocol.
*/
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sgs_selector
    import sgs_pkg::*;
#(
    parameter int DW = 32,
    parameter int TICK_CYCLES = DLY_STEP_CYCLES,
    parameter int PCW = $clog2(TICK_CYCLES + 1)
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [DW-1:0] torque_cmd,
    input wire logic signed [DW-1:0] vel_cmd_change,
    input wire logic signed [DW-1:0] vel_cmd,
    input wire logic signed [DW-1:0] cmd_pos_enc,
    input wire logic signed [DW-1:0] act_pos_enc,
    input wire logic signed [DW-1:0] cmd_pos_ext,
    input wire logic signed [DW-1:0] act_pos_ext,
    input wire logic signed [DW-1:0] pos_cmd,
    input wire logic positioning_done,
    input wire logic signed [DW-1:0] act_speed,
    output logic gain_second,
    output logic [WGT_W-1:0] pos_gain_weight
);

    localparam logic [PCW-1:0] PRE_LAST = PCW'(TICK_CYCLES - 1);

    function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
        mag = v[DW-1] ? (~v + DW'(1)) : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic second_gain_enable;
    logic [1:0] control_mode;
    logic [3*MODE_W-1:0] mode_word;
    logic [LVL_W-1:0] lvl [SETS];
    logic [LVL_W-1:0] hys [SETS];
    logic [DLY_W-1:0] dly [SETS];
    logic [DLY_W-1:0] position_gain_ramp_time;
    sgs_gain_e gain_state;
    sgs_gain_e next_gain_state;

    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic [7:0] set_off;
    logic [1:0] rsel;
    logic in_set;
    logic [31:0] rd_word;
    logic timer_busy;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign addr_hit = (paddr[1:0] == 2'b00) && (paddr <= RAMP_OFF);
    assign set_off = paddr - SET_BASE_OFF;
    assign rsel = set_off[4:3];
    assign in_set = (paddr >= SET_BASE_OFF) && (paddr < STAT_OFF);
    // no wait states; an unmapped word answers with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_gain_enable <= CTRL_EN_RST;
            control_mode <= CTRL_CM_RST;
        end
        else if (wr_en && paddr == CTRL_OFF)
        begin
            second_gain_enable <= pwdata[CTRL_EN_BIT];
            control_mode <= pwdata[CTRL_CM_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_word <= {MODE_RST, MODE_RST, MODE_RST};
        else if (wr_en && paddr == MODE_OFF)
            mode_word <= pwdata[3*MODE_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            position_gain_ramp_time <= RAMP_RST;
        else if (wr_en && paddr == RAMP_OFF)
            position_gain_ramp_time <= pwdata[DLY_W-1:0];
    end

    // one level/hysteresis word and one delay word per control set
    for (genvar gi = 0; gi < SETS; gi++)
    begin : g_set
        localparam logic [7:0] LOFF = SET_BASE_OFF + 8'(gi * SET_STRIDE);
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                lvl[gi] <= LVL_RST;
                hys[gi] <= HYS_RST;
                dly[gi] <= DLY_RST;
            end
            else if (wr_en && paddr == LOFF)
            begin
                lvl[gi] <= pwdata[LVL_LSB +: LVL_W];
                hys[gi] <= pwdata[HYS_LSB +: LVL_W];
            end
            else if (wr_en && paddr == LOFF + SET_DLY_OFF)
            begin
                dly[gi] <= pwdata[DLY_W-1:0];
            end
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (paddr == CTRL_OFF)
        begin
            rd_word[CTRL_EN_BIT] = second_gain_enable;
            rd_word[CTRL_CM_LSB +: 2] = control_mode;
        end
        else if (paddr == MODE_OFF)
            rd_word[3*MODE_W-1:0] = mode_word;
        else if (in_set && paddr[2])
            rd_word[DLY_W-1:0] = dly[rsel];
        else if (in_set)
        begin
            rd_word[LVL_LSB +: LVL_W] = lvl[rsel];
            rd_word[HYS_LSB +: LVL_W] = hys[rsel];
        end
        else if (paddr == STAT_OFF)
        begin
            rd_word[STAT_GAIN_BIT] = gain_second;
            rd_word[STAT_TIMING_BIT] = timer_busy;
            rd_word[STAT_WGT_LSB +: WGT_W] = pos_gain_weight;
        end
        else if (paddr == RAMP_OFF)
            rd_word[DLY_W-1:0] = position_gain_ramp_time;
    end

    // read data is caught in the setup cycle and held through the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= addr_hit ? rd_word : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // thresholds and process values

    logic is_vel;
    logic in_pos_fc;
    logic [1:0] set_idx;
    logic [MODE_W-1:0] act_mode;
    logic [LVL_W-1:0] lvl_sel;
    logic [LVL_W-1:0] hys_sel;
    logic [LVL_W-1:0] hys_eff;
    logic [DLY_W-1:0] dly_sel;
    logic [DW-1:0] up_ext;
    logic [DW-1:0] dn_ext;
    logic [DW-1:0] pos_dev;
    logic [DW-1:0] trq_mag;
    logic [DW-1:0] vchg_mag;
    logic [DW-1:0] vcmd_mag;
    logic [DW-1:0] dev_mag;
    logic [DW-1:0] spd_mag;

    assign is_vel = control_mode == CM_VEL;
    assign in_pos_fc = (control_mode == CM_POS) || (control_mode == CM_FULL);
    // full-closed shares the position control set
    assign set_idx = is_vel ? 2'd1 : (control_mode == CM_TRQ) ? 2'd2 : 2'd0;
    assign act_mode = mode_word[set_idx * MODE_W +: MODE_W];
    assign lvl_sel = lvl[set_idx];
    assign hys_sel = hys[set_idx];
    assign dly_sel = dly[set_idx];
    assign hys_eff = (lvl_sel < hys_sel) ? lvl_sel : hys_sel;
    assign up_ext = DW'(lvl_sel) + DW'(hys_eff);
    assign dn_ext = DW'(lvl_sel - hys_eff);
    // the scale pair is used in full-closed, so level counts in scale units
    assign pos_dev = (control_mode == CM_FULL) ? (cmd_pos_ext - act_pos_ext)
                                               : (cmd_pos_enc - act_pos_enc);
    assign trq_mag = mag(torque_cmd);
    assign vchg_mag = mag(vel_cmd_change);
    assign vcmd_mag = mag(vel_cmd);
    assign dev_mag = mag(pos_dev);
    assign spd_mag = mag(act_speed);

    ////////////////////////////////////////////////////////////////////////
    // switching conditions

    logic force_first;
    logic force_second;
    logic up_cond;
    logic ret_cond;

    always_comb
    begin
        force_first = 1'b0;
        force_second = 1'b0;
        up_cond = 1'b0;
        ret_cond = 1'b0;
        case (act_mode)
            SW_FIX_FIRST: force_first = 1'b1;
            SW_FIX_SECOND: force_second = 1'b1;
            SW_TORQUE:
            begin
                up_cond = trq_mag > up_ext;
                ret_cond = trq_mag < dn_ext;
            end
            SW_VEL_CHG:
            begin
                force_first = !is_vel;
                up_cond = vchg_mag > up_ext;
                ret_cond = vchg_mag < dn_ext;
            end
            SW_VEL_CMD:
            begin
                force_first = !(in_pos_fc || is_vel);
                up_cond = vcmd_mag > up_ext;
                ret_cond = vcmd_mag < dn_ext;
            end
            SW_POS_DEV:
            begin
                force_first = !in_pos_fc;
                up_cond = dev_mag > up_ext;
                ret_cond = dev_mag < dn_ext;
            end
            SW_POS_CMD:
            begin
                force_first = !in_pos_fc;
                up_cond = pos_cmd != '0;
                ret_cond = pos_cmd == '0;
            end
            SW_NOT_INP:
            begin
                force_first = !in_pos_fc;
                up_cond = !positioning_done;
                ret_cond = positioning_done;
            end
            SW_ACT_SPD:
            begin
                force_first = !in_pos_fc;
                up_cond = spd_mag > up_ext;
                ret_cond = spd_mag < dn_ext;
            end
            SW_CMD_SPD:
            begin
                force_first = !in_pos_fc;
                up_cond = pos_cmd != '0;
                ret_cond = (pos_cmd == '0) && (spd_mag < dn_ext);
            end
            // reserved codes act as fixed first gain, the safe side
            default: force_first = 1'b1;
        endcase
        if (!second_gain_enable)
        begin
            force_first = 1'b1;
            force_second = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gain state and return delay

    logic timer_run;
    logic ret_done;

    assign timer_run = (gain_state == GAIN_SECOND) && !force_first && !force_second && ret_cond;

    sgs_delay_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .run(timer_run),
        .delay(dly_sel),
        .done(ret_done),
        .busy(timer_busy)
    );

    always_comb
    begin
        next_gain_state = gain_state;
        case (gain_state)
            GAIN_FIRST:
                if (force_second || (!force_first && up_cond))
                    next_gain_state = GAIN_SECOND;
            GAIN_SECOND:
                if (force_first || ret_done)
                    next_gain_state = GAIN_FIRST;
            default: next_gain_state = GAIN_FIRST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_state <= GAIN_FIRST;
        else
            gain_state <= next_gain_state;
    end

    // velocity gain, integrator, detection and torque filters follow this at once
    assign gain_second = gain_state == GAIN_SECOND;

    ////////////////////////////////////////////////////////////////////////
    // position gain ramp: weight 0 is all first set, WGT_MAX all second

    logic [PCW-1:0] pre_cnt;
    logic ramp_tick;
    logic [DLY_W-1:0] ramp_cnt;
    logic [WGT_W-1:0] wgt_target;
    logic ramp_step;

    assign ramp_tick = pre_cnt == PRE_LAST;
    assign wgt_target = gain_second ? WGT_MAX : '0;
    assign ramp_step = ramp_tick && (ramp_cnt + 1'b1 >= position_gain_ramp_time);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_cnt <= '0;
        else
            pre_cnt <= ramp_tick ? '0 : pre_cnt + 1'b1;
    end

    // one weight step per ramp_time ticks; a full swing takes WGT_MAX steps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_cnt <= '0;
            pos_gain_weight <= '0;
        end
        else if (position_gain_ramp_time == '0 || pos_gain_weight == wgt_target)
        begin
            ramp_cnt <= '0;
            pos_gain_weight <= wgt_target;
        end
        else if (ramp_step)
        begin
            ramp_cnt <= '0;
            pos_gain_weight <= gain_second ? pos_gain_weight + 1'b1
                                           : pos_gain_weight - 1'b1;
        end
        else if (ramp_tick)
        begin
            ramp_cnt <= ramp_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_waiting;
        gain_second && timer_run;
    endsequence

    sequence s_lapsed;
        gain_second && !force_first && !force_second && !ret_cond;
    endsequence

    a_disabled_first: assert property (
        !second_gain_enable ##1 !second_gain_enable |-> !gain_second ##1 !gain_second)
        else $error("second gain while switching disabled");
    a_fixed_first: assert property (
        second_gain_enable && act_mode == SW_FIX_FIRST |=> !gain_second)
        else $error("mode 0 did not hold first gain");
    a_fixed_second: assert property (
        second_gain_enable && act_mode == SW_FIX_SECOND |=> gain_second)
        else $error("mode 1 did not hold second gain");
    a_torque_shift: assert property (
        second_gain_enable && act_mode == SW_TORQUE && !gain_second
        && trq_mag > up_ext |=> gain_second)
        else $error("torque above threshold did not switch");
    a_vel_only_gate: assert property (
        second_gain_enable && act_mode == SW_VEL_CHG && !is_vel |=> !gain_second)
        else $error("mode 4 left first gain outside velocity control");
    a_lapse_holds: assert property (
        s_lapsed |=> gain_second)
        else $error("returned to first gain without return condition");
    a_zero_delay: assert property (
        s_waiting ##0 dly_sel == '0 |=> !gain_second)
        else $error("zero delay did not return at once");
    a_one_step_delay: assert property (
        $rose(timer_run) ##0 dly_sel == 14'h0001 |-> !ret_done ##1 gain_second)
        else $error("returned before one delay step");
    a_hyst_clamp: assert property (
        hys_eff <= lvl_sel && dn_ext <= DW'(lvl_sel))
        else $error("hysteresis exceeds level");
    a_stay_first: assert property (
        !gain_second && !force_second && !(up_cond && !force_first) |=> !gain_second)
        else $error("left first gain without a cause");
    a_ramp_direct: assert property (
        position_gain_ramp_time == '0 |=> pos_gain_weight == ($past(gain_second) ? WGT_MAX : '0))
        else $error("weight did not follow gain with zero ramp time");
    a_bus_error: assert property (
        psel && penable && !addr_hit |-> pslverr && pready)
        else $error("unmapped access not flagged");

endmodule // sgs_selector
`default_nettype wire

// ==== tb/sgs_selector_test.sv ====
/*
 sgs_selector_test: random self-checking bench with a cycle model of the gain state.
 assumes the selector answers apb with pready and takes TICK_CYCLES per delay step.
*/
`timescale 1ns/1ps
`default_nettype none
module sgs_selector_test
    import sgs_pkg::*;
;
    localparam int T = 4;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, positioning_done, gain_second;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic signed [31:0] torque_cmd, vel_cmd_change, vel_cmd, pos_cmd, act_speed;
    logic signed [31:0] cmd_pos_enc, act_pos_enc, cmd_pos_ext, act_pos_ext;
    logic [WGT_W-1:0] pos_gain_weight;
    logic [31:0] sh [0:9];
    logic e, chk_on;
    int fails = 0, n_compared = 0, mg, mc, mw, cm, md, st, lv, hy, dl, i, n, ok, up, dn, sa;
    longint x;
    always #5 pclk = ~pclk;
    sgs_selector #(.TICK_CYCLES(T)) sgs_selector_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .torque_cmd(torque_cmd),
        .vel_cmd_change(vel_cmd_change), .vel_cmd(vel_cmd), .cmd_pos_enc(cmd_pos_enc),
        .act_pos_enc(act_pos_enc), .cmd_pos_ext(cmd_pos_ext), .act_pos_ext(act_pos_ext),
        .pos_cmd(pos_cmd), .positioning_done(positioning_done), .act_speed(act_speed),
        .gain_second(gain_second), .pos_gain_weight(pos_gain_weight));
    ////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] msk(input int k);
        case (k)
            0: return 32'h0000_0007;
            1: return 32'h0000_0fff;
            2, 4, 6: return 32'h7fff_7fff;
            3, 5, 7, 9: return 32'h0000_3fff;
            default: return 32'h0000_0000;
        endcase
    endfunction
    function automatic int rnd();
        return int'($urandom % 121) - 60;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // master holds the whole request until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        if (w && a[1:0] == 2'h0 && a <= 8'h24 && a != 8'h20)
            sh[a[7:2]] <= d & msk(a[7:2]);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    // reference gain state, evaluated from the values sampled at each edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mg <= 0;
            mc <= 0;
            mw <= 0;
        end
        else
        begin
            mw <= mg ? 255 : 0;
            cm = sh[0][2:1];
            md = cm == 1 ? sh[1][7:4] : cm == 2 ? sh[1][11:8] : sh[1][3:0];
            st = cm == 1 ? 4 : cm == 2 ? 6 : 2;
            lv = sh[st][14:0];
            hy = sh[st][30:16];
            if (hy > lv)
                hy = lv;
            dl = sh[st+1][13:0];
            case (md)
                3: x = torque_cmd;
                4: x = vel_cmd_change;
                5: x = vel_cmd;
                6: x = cm == 3 ? cmd_pos_ext - act_pos_ext : cmd_pos_enc - act_pos_enc;
                default: x = act_speed;
            endcase
            if (x < 0)
                x = -x;
            ok = md < 2 || md == 3 || (md == 4 && cm == 1) || (md == 5 && cm != 2)
                || (md > 5 && md < 11 && cm != 1 && cm != 2);
            up = (md == 7 || md == 10) ? pos_cmd != 0 : md == 8 ? !positioning_done
                : x > lv + hy;
            dn = md == 7 ? pos_cmd == 0 : md == 8 ? positioning_done
                : md == 10 ? (pos_cmd == 0 && x < lv - hy) : x < lv - hy;
            if (!sh[0][0] || !ok || md == 0)
                mg <= 0;
            else if (md == 1)
                mg <= 1;
            else if (!mg)
                mg <= up;
            else if (dn && mc == dl * T)
                mg <= 0;
            mc <= (mg && ok && md > 1 && sh[0][0] && dn && mc != dl * T) ? mc + 1 : 0;
        end
    end
    always @(negedge pclk)
    begin
        if (chk_on)
        begin
            chk(32'(gain_second), 32'(mg));
            chk(32'(gain_second), 32'(mg));
            chk(32'(gain_second), 32'(mg));
            chk(32'(pos_gain_weight), 32'(mw));
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #300_000;
        fails++;
        close_out();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, chk_on, positioning_done} = '0;
        {torque_cmd, vel_cmd_change, vel_cmd, pos_cmd, act_speed} = '0;
        {cmd_pos_enc, act_pos_enc, cmd_pos_ext, act_pos_ext} = '0;
        for (i = 0; i < 10; i++)
            sh[i] = 32'h0000_0000;
        void'($urandom(32'hea2e));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 10; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk(r, 32'h0000_0000);
        end
        apb(1'b0, 8'h28, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, 8'h03, 32'hffff_ffff);
        chk(32'(e), 32'h0000_0001);
        for (i = 0; i < 10; i++)
        begin
            apb(1'b1, 8'(i * 4), $urandom);
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            if (i != 8)
                chk(r, sh[i]);
        end
        apb(1'b1, 8'h24, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk_on <= 1'b1;
        // hysteresis may exceed level on purpose, delays stay short to keep runs brief
        for (n = 0; n < 128; n++)
        begin
            i = $urandom % 4;
            apb(1'b1, 8'h00, 32'((i << 1) | (($urandom % 4) != 0)));
            apb(1'b1, 8'h04, 32'(($urandom % 16) * 12'h111));
            // own address variable: the reference model rewrites st at every edge
            sa = i == 1 ? 8'h10 : i == 2 ? 8'h18 : 8'h08;
            apb(1'b1, 8'(sa), 32'((($urandom % 30) << 16) | ($urandom % 40)));
            apb(1'b1, 8'(sa + 4), 32'($urandom % 4));
            repeat (60)
            begin
                if ($urandom % 8 == 0)
                begin
                    torque_cmd <= rnd();
                    vel_cmd_change <= rnd();
                    vel_cmd <= rnd();
                    act_speed <= rnd();
                    cmd_pos_enc <= rnd();
                    act_pos_enc <= rnd();
                    cmd_pos_ext <= rnd();
                    act_pos_ext <= rnd();
                    pos_cmd <= ($urandom % 2) ? 0 : rnd();
                    positioning_done <= $urandom % 2;
                end
                @(posedge pclk);
            end
        end
        apb(1'b1, 8'h04, 32'h0000_0111);
        apb(1'b1, 8'h00, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        apb(1'b1, 8'h20, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(r & 32'h0000_ff01, 32'h0000_ff01);
        close_out();
    end
endmodule // sgs_selector_test
`default_nettype wire
